// ===== dcpb_ctrl.v
// Purpose: host sequencer for pll, dll and calibration bring-up of the sample clock
// Assumes: earlier power-up writes done; the device keeps lock bits honest
// Notes: go starts; busy, done and fail report; lock polled up to a limit
`timescale 1ns/100ps
`include "dcpb_defines.vh"
module dcpb_ctrl #(
   parameter PLL_WAIT = `DCPB_PLL_WAIT_CYC,
   parameter CAL_WAIT = `DCPB_CAL_WAIT_CYC,
   parameter POLL_MAX = `DCPB_POLL_MAX
) (
   input wire ref_clk,
   input wire rst_b,
   input wire clk_en,
   input wire go,
   input wire [1:0] obs_div_code,
   input wire [5:0] fb_div,
   input wire [1:0] prediv_code,
   input wire vco_third_rate_select,
   input wire vco_half_rate_select,
   input wire rate_high,
   output reg busy,
   output reg done,
   output reg fail,
   output reg [3:0] fail_step,
   output wire spi_sclk,
   output wire spi_cs_b,
   output wire spi_sdio_o,
   output wire spi_sdio_oe_b,
   input wire spi_sdio_i
);
   localparam N = 21;
   localparam S_IDLE = 4'h0;
   localparam S_ISSUE = 4'h1;
   localparam S_XFER = 4'h2;
   localparam S_WAIT = 4'h3;
   localparam S_END = 4'h4;
   // one-hot phase state
   localparam [4:0] P_IDLE = 5'b00001;
   localparam [4:0] P_ISSUE = 5'b00010;
   localparam [4:0] P_XFER = 5'b00100;
   localparam [4:0] P_WAIT = 5'b01000;
   localparam [4:0] P_END = 5'b10000;
   reg [4:0] state;
   reg [4:0] step;
   reg [7:0] polls;
   reg [1:0] obs_q, pre_q;
   reg [5:0] fb_q;
   reg third_q, half_q, high_q;
   reg sp_start;
   reg tm_load;
   reg [22:0] tm_count;
   wire sp_done;
   wire tm_exp;
   wire [7:0] sp_rdata;
   reg stp_rd;
   reg [14:0] stp_addr;
   reg [7:0] stp_data;
   reg [1:0] stp_wait;
   // step table: write, read-check, or write then wait
   always @* begin
      stp_rd = 1'b0;
      stp_wait = 2'd0;
      stp_addr = 15'h0000;
      stp_data = `DCPB_ZERO;
      case (step)
         5'd0: begin
            stp_addr = `DCPB_REG_FB_DIV;
            stp_data = {obs_q, fb_q}; // R1 R2
         end
         5'd1: begin
            stp_addr = `DCPB_REG_PREDIV;
            stp_data = {`DCPB_PREDIV_UPPER, pre_q}; // R3 R4
         end
         5'd2: begin
            stp_addr = `DCPB_REG_VCO_POST;
            stp_data = {`DCPB_POST_UPPER, third_q, half_q}; // R3 R7 R8
         end
         5'd3: begin
            stp_addr = `DCPB_REG_VCO_RESET;
            stp_data = `DCPB_VCO_RST_ON; // R10
         end
         5'd4: begin
            stp_addr = `DCPB_REG_VCO_RESET;
            stp_wait = 2'd1; // R10
         end
         5'd5: begin
            stp_addr = `DCPB_REG_PLL_STAT;
            stp_rd = 1'b1; // R11
         end
         5'd6: stp_addr = `DCPB_REG_DLINE_PWR;
         5'd7: stp_addr = `DCPB_REG_DLL_UPDATE; // R12
         5'd8: begin
            stp_addr = `DCPB_REG_DLL_UPDATE;
            stp_data = `DCPB_ONE; // R12
         end
         5'd9: stp_addr = `DCPB_REG_DLL_UPDATE; // R12
         5'd10: begin
            stp_addr = `DCPB_REG_DLL_SEARCH;
            stp_data = high_q ? `DCPB_SEARCH_HI : `DCPB_SEARCH_LO; // R13
         end
         5'd11: begin
            stp_addr = `DCPB_REG_DLL_SEARCH;
            stp_data = (high_q ? `DCPB_SEARCH_HI : `DCPB_SEARCH_LO) | `DCPB_ONE; // R14
         end
         5'd12: begin
            stp_addr = `DCPB_REG_DLL_STAT_EN;
            stp_data = `DCPB_ONE; // R15
         end
         5'd13: begin
            stp_addr = `DCPB_REG_DLL_STAT;
            stp_rd = 1'b1; // R16
         end
         5'd14: begin
            stp_addr = `DCPB_REG_CAL_SET_A;
            stp_data = `DCPB_CAL_A_VAL; // R17
         end
         5'd15: begin
            stp_addr = `DCPB_REG_CAL_CTL_A;
            stp_data = `DCPB_CAL_CTL_A_VAL; // R18
         end
         5'd16: begin
            stp_addr = `DCPB_REG_CAL_SET_B;
            stp_data = `DCPB_CAL_B_VAL; // R17
            stp_wait = 2'd2; // R18
         end
         5'd17: begin
            stp_addr = `DCPB_REG_CAL_SET_B;
            stp_data = `DCPB_CAL_B_FINAL; // R18
         end
         5'd18: begin
            stp_addr = `DCPB_REG_CAL_CTL_B;
            stp_data = `DCPB_CAL_CTL_B_VAL; // R18
         end
         default: stp_addr = 15'h0000;
      endcase
   end
   localparam [4:0] LAST = 5'd18;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= P_IDLE;
         step <= 5'd0;
         polls <= 8'h00;
         obs_q <= 2'b00;
         pre_q <= 2'b00;
         fb_q <= 6'h00;
         third_q <= 1'b0;
         half_q <= 1'b0;
         high_q <= 1'b0;
         sp_start <= 1'b0;
         tm_load <= 1'b0;
         tm_count <= 23'h000000;
         busy <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         fail_step <= 4'h0;
      end else if (clk_en) begin
         sp_start <= 1'b0;
         tm_load <= 1'b0;
         case (state)
            P_IDLE: begin
               if (go) begin
                  obs_q <= obs_div_code;
                  // user picks the code that keeps the pfd in range
                  pre_q <= prediv_code; // R5 R6
                  fb_q <= fb_div;
                  // both selects together is illegal; third-rate wins
                  third_q <= vco_third_rate_select; // R9
                  half_q <= vco_half_rate_select & ~vco_third_rate_select; // R9
                  high_q <= rate_high;
                  step <= 5'd0;
                  polls <= 8'h00;
                  busy <= 1'b1;
                  done <= 1'b0;
                  fail <= 1'b0;
                  fail_step <= 4'h0;
                  state <= P_ISSUE;
               end
            end
            P_ISSUE: begin
               sp_start <= 1'b1;
               state <= P_XFER;
            end
            P_XFER: begin
               if (sp_done) begin
                  if (stp_rd && !sp_rdata[`DCPB_LOCK_BIT]) begin
                     // R11 R16
                     if (polls == POLL_MAX[7:0] - 8'h01) begin
                        fail <= 1'b1;
                        fail_step <= step[3:0];
                        busy <= 1'b0;
                        state <= P_END;
                     end else begin
                        polls <= polls + 8'h01;
                        state <= P_ISSUE;
                     end
                  end else if (stp_wait != 2'd0) begin
                     tm_load <= 1'b1;
                     tm_count <= (stp_wait == 2'd1) ? PLL_WAIT[22:0] : CAL_WAIT[22:0];
                     state <= P_WAIT;
                  end else if (step == LAST) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                     state <= P_END;
                  end else begin
                     step <= step + 5'd1;
                     polls <= 8'h00;
                     state <= P_ISSUE;
                  end
               end
            end
            P_WAIT: begin
               if (tm_exp) begin
                  step <= step + 5'd1;
                  polls <= 8'h00;
                  state <= P_ISSUE;
               end
            end
            P_END: begin
               if (go) begin
                  done <= 1'b0;
                  fail <= 1'b0;
                  state <= P_IDLE;
               end
            end
            default: state <= P_IDLE;
         endcase
      end
   end
   dcpb_spi u_spi (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .start(sp_start),
      .rd(stp_rd),
      .addr(stp_addr),
      .wdata(stp_data),
      .done(sp_done),
      .rdata(sp_rdata),
      .spi_sclk(spi_sclk),
      .spi_cs_b(spi_cs_b),
      .spi_sdio_o(spi_sdio_o),
      .spi_sdio_oe_b(spi_sdio_oe_b),
      .spi_sdio_i(spi_sdio_i)
   );
   dcpb_timer #(.W(23)) u_tmr (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .load(tm_load),
      .count(tm_count),
      .expired(tm_exp)
   );
endmodule // dcpb_ctrl

// ===== dcpb_defines.vh
// Purpose: constants for the sample-clock bring-up controller
// Assumes: device register map reached over 3-wire spi, 15-bit address
// Notes: How it works list below
//
// How it works
// R1: output divider code n divides by n+1
// R2: feedback divider equals rate times m over 8ref
// R3: keep predivider and post-divide upper bits default
// R4: predivider field holds divide value minus one
// R5: phase-detector frequency between 25 and 770 MHz
// R6: near 10 GHz VCO, pfd at most 225 MHz
// R7: third-rate select divides VCO by three
// R8: half-rate select divides VCO by two
// R9: never set half and third select together
// R10: reset VCO 0x02 then 0x00, wait 100 ms
// R11: read pll lock bit zero before continuing
// R12: pulse dll update 0x00, 0x01, 0x00
// R13: search mode 0x48 below 4.5 GHz, else 0x68
// R14: rewrite search mode with lowest bit set
// R15: enable dll status readout with 0x01
// R16: confirm dll lock bit zero before calibration
// R17: calibration writes 0x2a and 0x82 settings
// R18: 0x68 control, wait 1 ms, 0x83, 0x03
// R19: lock bits stay zero until stable lock
`ifndef DCPB_DEFINES_VH
`define DCPB_DEFINES_VH
`define DCPB_REG_CAL_SET_A 15'h0050
`define DCPB_REG_CAL_SET_B 15'h0051
`define DCPB_REG_CAL_CTL_A 15'h0061
`define DCPB_REG_CAL_CTL_B 15'h0081
`define DCPB_REG_VCO_POST 15'h0094
`define DCPB_REG_DLINE_PWR 15'h00c0
`define DCPB_REG_DLL_SEARCH 15'h00c1
`define DCPB_REG_DLL_STAT 15'h00c3
`define DCPB_REG_DLL_STAT_EN 15'h00c7
`define DCPB_REG_DLL_UPDATE 15'h00db
`define DCPB_REG_VCO_RESET 15'h0792
`define DCPB_REG_PREDIV 15'h0793
`define DCPB_REG_FB_DIV 15'h0799
`define DCPB_REG_PLL_STAT 15'h07b5
`define DCPB_PREDIV_UPPER 6'h06
`define DCPB_POST_UPPER 6'h00
`define DCPB_VCO_RST_ON 8'h02
`define DCPB_ZERO 8'h00
`define DCPB_ONE 8'h01
`define DCPB_SEARCH_LO 8'h48
`define DCPB_SEARCH_HI 8'h68
`define DCPB_CAL_A_VAL 8'h2a
`define DCPB_CAL_CTL_A_VAL 8'h68
`define DCPB_CAL_B_VAL 8'h82
`define DCPB_CAL_B_FINAL 8'h83
`define DCPB_CAL_CTL_B_VAL 8'h03
`define DCPB_LOCK_BIT 0
`define DCPB_CLK_HZ 40000000
`define DCPB_PLL_WAIT_MS 100
`define DCPB_CAL_WAIT_MS 1
`define DCPB_PLL_WAIT_CYC (`DCPB_CLK_HZ / 1000 * `DCPB_PLL_WAIT_MS)
`define DCPB_CAL_WAIT_CYC (`DCPB_CLK_HZ / 1000 * `DCPB_CAL_WAIT_MS)
`define DCPB_SCLK_HALF 4
`define DCPB_POLL_MAX 16
`endif

// ===== dcpb_spi.v
// Purpose: one 24-bit serial register access (r/w bit, 15-bit address, 8 data)
// Assumes: mode 0, msb first, 3-wire shared data pin
// Notes: data pin split into input, output and active-low enable
`timescale 1ns/100ps
`include "dcpb_defines.vh"
module dcpb_spi #(
   parameter HALF = `DCPB_SCLK_HALF
) (
   input wire ref_clk,
   input wire rst_b,
   input wire clk_en,
   input wire start,
   input wire rd,
   input wire [14:0] addr,
   input wire [7:0] wdata,
   output reg done,
   output reg [7:0] rdata,
   output reg spi_sclk,
   output reg spi_cs_b,
   output reg spi_sdio_o,
   output reg spi_sdio_oe_b,
   input wire spi_sdio_i
);
   reg [23:0] shreg;
   reg [4:0] bitn;
   reg [7:0] hcnt;
   reg busy;
   reg rd_q;
   reg s1, s2;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         shreg <= 24'h000000;
         bitn <= 5'h00;
         hcnt <= 8'h00;
         busy <= 1'b0;
         rd_q <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         spi_sclk <= 1'b0;
         spi_cs_b <= 1'b1;
         spi_sdio_o <= 1'b0;
         spi_sdio_oe_b <= 1'b1;
         s1 <= 1'b0;
         s2 <= 1'b0;
      end else if (clk_en) begin
         s1 <= spi_sdio_i;
         s2 <= s1;
         done <= 1'b0;
         if (!busy) begin
            if (start) begin
               busy <= 1'b1;
               rd_q <= rd;
               shreg <= {rd, addr, wdata};
               spi_sdio_o <= rd;
               spi_sdio_oe_b <= 1'b0;
               spi_cs_b <= 1'b0;
               bitn <= 5'h00;
               hcnt <= 8'h00;
            end
         end else if (hcnt != HALF[7:0] - 8'h01) begin
            hcnt <= hcnt + 8'h01;
         end else begin
            hcnt <= 8'h00;
            if (!spi_sclk) begin
               spi_sclk <= 1'b1;
               // sample at the sclk rise via synchronised input, which holds the pin from two ref_clk cycles before the rise
               if (bitn >= 5'h10)
                  rdata <= {rdata[6:0], s2};
            end else begin
               spi_sclk <= 1'b0;
               if (bitn == 5'h17) begin
                  busy <= 1'b0;
                  spi_cs_b <= 1'b1;
                  spi_sdio_oe_b <= 1'b1;
                  done <= 1'b1;
               end else begin
                  bitn <= bitn + 5'h01;
                  shreg <= {shreg[22:0], 1'b0};
                  spi_sdio_o <= shreg[22];
                  // turn the pin around for read data
                  if (rd_q && bitn == 5'h0f)
                     spi_sdio_oe_b <= 1'b1;
               end
            end
         end
      end
   end
endmodule // dcpb_spi

// ===== dcpb_timer.v
// Purpose: millisecond wait counter
// Assumes: load pulses restart it
// Notes: expired is a one-cycle pulse
`timescale 1ns/100ps
module dcpb_timer #(
   parameter W = 23
) (
   input wire ref_clk,
   input wire rst_b,
   input wire clk_en,
   input wire load,
   input wire [W-1:0] count,
   output reg expired
);
   reg [W-1:0] cnt;
   reg run;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= {W{1'b0}};
         run <= 1'b0;
         expired <= 1'b0;
      end else if (clk_en) begin
         expired <= 1'b0;
         if (load) begin
            cnt <= count;
            run <= 1'b1;
         end else if (run) begin
            if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
               run <= 1'b0;
               expired <= 1'b1;
            end else
               cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // dcpb_timer

// ===== dcpb_chk.sv
// Purpose: port checks of the bring-up sequencer
// Assumes: clk_en pauses only stretch sclk phases
// Notes: bound to dcpb_ctrl
`timescale 1ns/100ps
module dcpb_chk (
   input wire ref_clk,
   input wire rst_b,
   input wire clk_en,
   input wire go,
   input wire busy,
   input wire done,
   input wire fail,
   input wire [3:0] fail_step,
   input wire spi_sclk,
   input wire spi_cs_b,
   input wire spi_sdio_oe_b
);
   reg [4:0] rises;
   reg sclk_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rises <= 5'h00;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= spi_sclk;
         rises <= spi_cs_b ? 5'h00 : rises + {4'h0, spi_sclk & ~sclk_q};
      end
   end
   chk_frame_clocks: assert property ($rose(spi_cs_b) |-> rises == 5'h18)
      else $error("frame length");
   chk_sclk_idle: assert property (spi_cs_b |-> !spi_sclk)
      else $error("sclk outside frame");
   chk_pin_release: assert property (spi_cs_b |-> spi_sdio_oe_b)
      else $error("pin driven outside frame");
   chk_half_period: assert property ($changed(spi_sclk) |=> $stable(spi_sclk) [*3])
      else $error("short half period");
   chk_go_start: assert property (go && clk_en && !busy && !done && !fail |=> busy ##[1:2] !spi_cs_b)
      else $error("go not taken");
   chk_end_flag: assert property ($fell(busy) |-> ##[0:1] done ^ fail)
      else $error("no end flag");
   chk_flag_stands: assert property ((done || fail) && !go |=> $stable(done) && $stable(fail))
      else $error("end flag dropped");
   chk_fail_step: assert property ($rose(fail) |-> fail_step == 4'h5 || fail_step == 4'hd)
      else $error("bad fail step");
endmodule // dcpb_chk
bind dcpb_ctrl dcpb_chk chk (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .go(go), .busy(busy), .done(done),
   .fail(fail), .fail_step(fail_step), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_sdio_oe_b(spi_sdio_oe_b));

// ===== dcpb_dev.sv
// Purpose: device side of the serial register port
// Assumes: 3-wire mode 0, 24-bit frames
// Notes: logs frames with end times; lock after set read counts
`timescale 1ns/100ps
module dcpb_dev (
   input wire spi_sclk,
   input wire spi_cs_b,
   input wire spi_sdio_o,
   input wire spi_sdio_oe_b,
   output wire spi_sdio_i,
   input wire [7:0] pll_polls,
   input wire [7:0] dll_polls
);
   reg [7:0] mem [0:2047];
   reg [23:0] log [0:63];
   time t_end [0:63];
   reg [23:0] sh;
   reg [7:0] rd_byte;
   reg [4:0] cnt;
   reg drv, dbit, last, rdf, vco_pulsed;
   integer n, pll_rd, dll_rd;
   wire [2:0] obs_ratio = {1'b0, mem[11'h799][7:6]} + 3'h1;
   wire [2:0] ref_ratio = {1'b0, mem[11'h793][1:0]} + 3'h1;
   wire [1:0] vco_ratio = mem[11'h094][1] ? 2'h3 : (mem[11'h094][0] ? 2'h2 : 2'h1);
   // released pin toggles, never holds a stale bit
   assign spi_sdio_i = !spi_sdio_oe_b ? spi_sdio_o : (drv ? dbit : ~last);
   function [7:0] rd_val(input [14:0] a);
      begin
         if (a == 15'h07b5) rd_val = {7'h00, vco_pulsed && pll_rd >= pll_polls};
         else if (a == 15'h00c3) rd_val = {7'h00, mem[11'h0c7] == 8'h01 && dll_rd >= dll_polls};
         else rd_val = mem[a[10:0]];
      end
   endfunction
   initial begin
      {cnt, drv, last, rdf, vco_pulsed} = 9'h000;
      n = 0;
   end
   always @(posedge spi_sclk) begin
      if (!spi_cs_b) begin
         sh = {sh[22:0], spi_sdio_i};
         last = spi_sdio_i;
         cnt = cnt + 5'h01;
         if (cnt == 5'h10) begin
            rdf = sh[15];
            if (rdf && sh[14:0] == 15'h07b5) pll_rd = pll_rd + 1;
            if (rdf && sh[14:0] == 15'h00c3) dll_rd = dll_rd + 1;
            rd_byte = rd_val(sh[14:0]);
         end
      end
   end
   always @(negedge spi_sclk) begin
      drv = !spi_cs_b && rdf && cnt >= 5'h10 && cnt < 5'h18;
      dbit = rd_byte[5'h17 - cnt];
   end
   always @(posedge spi_cs_b) begin
      if (cnt == 5'h18 && n < 64) begin
         if (!sh[23] && sh[22:8] == 15'h0792) vco_pulsed = sh[7:0] == 8'h00 && mem[11'h792] == 8'h02;
         if (!sh[23]) mem[sh[18:8]] = sh[7:0];
         log[n] = sh[23] ? {sh[23:8], rd_byte} : sh;
         t_end[n] = $time;
         n = n + 1;
      end
      {cnt, drv, rdf} = 7'h00;
   end
endmodule // dcpb_dev

// ===== test_dac_clock_pll_dll_bringup.sv
// Purpose: directed bring-up runs against the device model
// Assumes: short wait and poll parameters
// Notes: each run compares the whole frame log
`timescale 1ns/100ps
module test_dac_clock_pll_dll_bringup;
   localparam PW = 200;
   localparam CW = 50;
   localparam PM = 4;
   reg ref_clk, rst_b, clk_en, go, rate_high, third, half;
   reg [4:0] hold;
   reg [1:0] obs, prediv;
   reg [5:0] fb;
   reg [7:0] pll_polls, dll_polls;
   wire busy, done, fail, sclk, cs_b, sdo, oe_b, sdi;
   wire [3:0] fail_step;
   reg [23:0] exp_log [0:63];
   integer bad_count, checked, i, m;
   dcpb_ctrl #(.PLL_WAIT(PW), .CAL_WAIT(CW), .POLL_MAX(PM)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
      .go(go), .obs_div_code(obs), .fb_div(fb), .prediv_code(prediv), .vco_third_rate_select(third),
      .vco_half_rate_select(half), .rate_high(rate_high), .busy(busy), .done(done), .fail(fail),
      .fail_step(fail_step), .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_sdio_o(sdo), .spi_sdio_oe_b(oe_b),
      .spi_sdio_i(sdi));
   dcpb_dev dev (.spi_sclk(sclk), .spi_cs_b(cs_b), .spi_sdio_o(sdo), .spi_sdio_oe_b(oe_b), .spi_sdio_i(sdi),
      .pll_polls(pll_polls), .dll_polls(dll_polls));
   task chk(input string nm, input [23:0] e, input [23:0] s);
      begin
         checked = checked + 1;
         if (e !== s) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task ex(input [23:0] v);
      begin
         exp_log[m] = v;
         m = m + 1;
      end
   endtask
   task results;
      begin
         $display("compares %0d mismatches %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   task run(input h, input [1:0] o, input [5:0] f, input [1:0] p, input t3, input t2, input [7:0] pp,
      input [7:0] dp);
      begin
         {rate_high, obs, fb, prediv, third, half, pll_polls, dll_polls} = {h, o, f, p, t3, t2, pp, dp};
         dev.n = 0;
         dev.pll_rd = 0;
         dev.dll_rd = 0;
         dev.vco_pulsed = 1'b0;
         m = 0;
         ex({1'b0, 15'h0799, o, f});
         ex({1'b0, 15'h0793, 6'h06, p});
         ex({1'b0, 15'h0094, 6'h00, t3, t2 & ~t3});
         ex(24'h079202);
         ex(24'h079200);
         for (i = 1; i <= PM && i <= pp; i = i + 1) ex({16'h87b5, 7'h00, i == pp});
         if (pp <= PM) begin
            ex(24'h00c000);
            ex(24'h00db00);
            ex(24'h00db01);
            ex(24'h00db00);
            ex({16'h00c1, 2'b01, h, 5'h08});
            ex({16'h00c1, 2'b01, h, 5'h09});
            ex(24'h00c701);
            for (i = 1; i <= PM && i <= dp; i = i + 1) ex({16'h80c3, 7'h00, i == dp});
            if (dp <= PM) begin
               ex(24'h00502a);
               ex(24'h006168);
               ex(24'h005182);
               ex(24'h005183);
               ex(24'h008103);
            end
         end
         // go held on while busy must be ignored
         go = 1'b1;
         repeat (3) @(negedge ref_clk);
         chk("busy", 24'h1, {23'h0, busy});
         go = 1'b0;
         // a low clock enable must freeze the frame in progress
         hold = {sclk, cs_b, oe_b, sdo, busy};
         clk_en = 1'b0;
         repeat (5) @(negedge ref_clk);
         chk("frozen", {19'h0, hold}, {19'h0, sclk, cs_b, oe_b, sdo, busy});
         clk_en = 1'b1;
         for (i = 0; i < 20000 && done !== 1'b1 && fail !== 1'b1; i = i + 1) @(negedge ref_clk);
         chk("finished", 24'h1, {23'h0, done | fail});
         chk("obs ratio", {22'h0, o} + 24'h1, {21'h0, dev.obs_ratio});
         chk("ref ratio", {22'h0, p} + 24'h1, {21'h0, dev.ref_ratio});
         chk("vco ratio", t3 ? 24'h3 : (t2 ? 24'h2 : 24'h1), {22'h0, dev.vco_ratio});
         chk("frames", m, dev.n);
         for (i = 0; i < m; i = i + 1) chk("frame", exp_log[i], dev.log[i]);
         chk("end flags", {22'h0, pp <= PM && dp <= PM, pp > PM || dp > PM}, {22'h0, done, fail});
         if (fail === 1'b1) chk("fail step", pp > PM ? 24'h5 : 24'hd, {20'h0, fail_step});
         chk("pll wait", 24'h1, {23'h0, dev.t_end[5] - dev.t_end[4] >= (PW + 192) * 25});
         if (done === 1'b1) chk("cal wait", 24'h1, {23'h0, dev.t_end[m-2] - dev.t_end[m-3] >= (CW + 192) * 25});
         go = 1'b1;
         @(negedge ref_clk);
         go = 1'b0;
         @(negedge ref_clk);
         chk("idle", 24'h0, {21'h0, busy, done, fail});
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // five runs of at most about 5000 cycles each plus a short reset cut
   initial begin
      #(25 * 40000);
      bad_count = bad_count + 1;
      results;
   end
   initial begin
      bad_count = 0;
      checked = 0;
      rst_b = 1'b0;
      go = 1'b0;
      {rate_high, third, half, obs, prediv, fb, pll_polls, dll_polls} = 29'h0;
      clk_en = 1'b1;
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      run(1'b0, 2'b10, 6'h15, 2'b01, 1'b1, 1'b0, 8'h03, 8'h02);
      run(1'b1, 2'b11, 6'h3f, 2'b11, 1'b1, 1'b1, 8'h01, 8'h01);
      run(1'b0, 2'b00, 6'h01, 2'b00, 1'b0, 1'b1, 8'hff, 8'h01);
      run(1'b1, 2'b01, 6'h20, 2'b10, 1'b0, 1'b0, 8'h02, 8'hff);
      // reset cut into a frame: pins idle in reset and at the first edges after it
      go = 1'b1;
      repeat (40) @(negedge ref_clk);
      rst_b = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("in reset", 24'h5, {18'h0, busy, done, fail, cs_b, sclk, oe_b});
      rst_b = 1'b1;
      go = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("after reset", 24'h5, {18'h0, busy, done, fail, cs_b, sclk, oe_b});
      run(1'b0, 2'b01, 6'h10, 2'b00, 1'b0, 1'b1, 8'h01, 8'h01);
      results;
   end
endmodule // test_dac_clock_pll_dll_bringup
